// ### rtl/cantx_regs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a Wishbone slave with 32-bit word-aligned registers.
`ifndef CANTX_REGS_SVH
`define CANTX_REGS_SVH
`define CANTX_OFS_CTRL      6'h00
`define CANTX_OFS_TXCON0    6'h04
`define CANTX_OFS_TXCON1    6'h08
`define CANTX_OFS_TXCON2    6'h0c
`define CANTX_OFS_IRQ_STAT  6'h10
`define CANTX_OFS_IRQ_MASK  6'h14
`define CANTX_BIT_CAP       15
`define CANTX_BIT_SIDL      13
`define CANTX_BIT_ABORT_ALL_TX      12
`define CANTX_BIT_CKS       11
`define CANTX_POS_REQUESTED_MODE     8
`define CANTX_POS_CURRENT_MODE    5
`define CANTX_POS_INTERRUPT_SOURCE_CODE     1
`define CANTX_BIT_TX_ABORTED_FLAG     6
`define CANTX_BIT_TX_LOST_ARBITRATION_FLAG    5
`define CANTX_BIT_TX_ERROR_FLAG     4
`define CANTX_BIT_SEND_REQUEST     3
`define CANTX_POS_TX_PRIORITY     0
`define CANTX_RST_MODE      3'h4
`define CANTX_MODE_CHG_NS   200
`define CANTX_CLK_NS        40
`define CANTX_MODE_CHG_CYC  ((`CANTX_MODE_CHG_NS + `CANTX_CLK_NS - 1) / `CANTX_CLK_NS)
`endif

// ### rtl/cantx_pkg.sv
// Types shared by the control and transmit-buffer control block.
// Assumes cantx_regs.svh supplies the numeric constants.
package cantx_pkg;
   typedef enum logic [2:0] {
      CANTX_NORMAL = 3'h0,
      CANTX_DISABLE = 3'h1,
      CANTX_LOOPBACK = 3'h2,
      CANTX_LISTEN_ONLY = 3'h3,
      CANTX_CONFIG = 3'h4,
      CANTX_RSVD5 = 3'h5,
      CANTX_RSVD6 = 3'h6,
      CANTX_LISTEN_ALL = 3'h7
   } cantx_mode_t;

   typedef enum logic [1:0] {
      CANTX_IDLE,
      CANTX_SEND
   } cantx_tx_t;

   typedef struct packed {
      logic       send_request;
      logic [1:0] tx_priority;
      logic       tx_aborted_flag;
      logic       tx_lost_arbitration_flag;
      logic       tx_error_flag;
   } cantx_buf_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } cantx_wb_rsp_t;

   typedef struct packed {
      logic        rx_capture_enable;
      logic        stop_in_idle;
      logic        abort_all_tx;
      logic        master_clock_select;
      cantx_mode_t requested_mode;
      cantx_mode_t current_mode;
      logic [2:0]  mode_cnt;
      cantx_buf_t [2:0] buf_q;
      cantx_tx_t   tx_state;
      logic [1:0]  tx_sel;
      logic [6:0]  irq_stat;
      logic [6:0]  irq_mask;
      logic [1:0]  clk_div;
      cantx_wb_rsp_t rsp;
   } cantx_state_t;
endpackage

// ### rtl/cantx_ctrl.sv
// Control, status and transmit-buffer control of a CAN controller.
// Assumes a classic Wishbone master and a protocol engine with pulse events.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "cantx_regs.svh"

// Contract
// (RL1) Capture enable writable in every mode
// (RL2) Stop-in-idle halts controller on idle
// (RL3) Abort-all cancels all pending transmissions
// (RL4) Abort-all self-clears when aborts done
// (RL5) Clock select: 1 base, 0 four times
// (RL6) Requested-mode field encoding, two reserved
// (RL7) Current-mode field reports mode in effect
// (RL8) Interrupt code reports highest pending event
// (RL9) Unimplemented bits read zero, ignore writes
// (RL10) Aborted flag set when message aborted
// (RL11) Lost-arbitration flag set on lost arbitration
// (RL12) Error flag set on bus error
// (RL13) Setting send-request clears three flags
// (RL14) Writing one queues buffer for sending
// (RL15) Writing zero aborts a set request
// (RL16) Send-request self-clears on success
// (RL17) Two-bit priority, eleven highest
// (RL18) Highest priority first, ties to higher buffer
// (RL19) Reset: configuration mode, control bits zero
module cantx_ctrl
   import cantx_pkg::*;
#(
   parameter int MODE_CHG_CYC = `CANTX_MODE_CHG_CYC
)(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output      logic [31:0] wb_dat_o,
   output      logic        wb_ack_o,
   // Device and protocol engine
   input  wire logic        cpu_idle,
   input  wire logic        tx_done,
   input  wire logic        tx_lost_arb,
   input  wire logic        tx_bus_err,
   input  wire logic        ev_wake,
   input  wire logic        ev_rx0,
   input  wire logic        ev_rx1,
   input  wire logic        ev_err,
   output      logic        tx_start,
   output      logic [1:0]  tx_buf_sel,
   output      logic        tx_abort,
   output      logic        can_base_clock_en,
   output      logic        rx_capture_on,
   output      logic        module_halted,
   output      logic [2:0]  op_mode,
   output      logic        irq
);
   cantx_state_t st;
   cantx_state_t next_st;
   logic         wr;
   logic         rd;
   logic         halt;
   logic [6:0]   ev;
   logic [1:0]   best;
   logic         any_req;
   logic [2:0]   interrupt_source_code;
   logic [15:0]  ctrl_rd;
   logic [15:0]  txcon_rd [3];
   logic [6:0]   pend;

   assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !st.rsp.ack;
   assign rd   = wb_cyc_i && wb_stb_i && !st.rsp.ack;
   assign halt = st.stop_in_idle && cpu_idle; // RL2

   // Register read images
   always_comb
   begin
      ctrl_rd = 16'h0000; // RL9
      ctrl_rd[`CANTX_BIT_CAP]  = st.rx_capture_enable;
      ctrl_rd[`CANTX_BIT_SIDL] = st.stop_in_idle;
      ctrl_rd[`CANTX_BIT_ABORT_ALL_TX] = st.abort_all_tx;
      ctrl_rd[`CANTX_BIT_CKS]  = st.master_clock_select;
      ctrl_rd[`CANTX_POS_REQUESTED_MODE +: 3]  = st.requested_mode;
      ctrl_rd[`CANTX_POS_CURRENT_MODE +: 3] = st.current_mode; // RL7
      ctrl_rd[`CANTX_POS_INTERRUPT_SOURCE_CODE +: 3]  = interrupt_source_code;
   end

   for (genvar g = 0; g < 3; g++)
   begin : g_rd
      always_comb
      begin
         txcon_rd[g] = 16'h0000; // RL9
         txcon_rd[g][`CANTX_BIT_TX_ABORTED_FLAG]  = st.buf_q[g].tx_aborted_flag;
         txcon_rd[g][`CANTX_BIT_TX_LOST_ARBITRATION_FLAG] = st.buf_q[g].tx_lost_arbitration_flag;
         txcon_rd[g][`CANTX_BIT_TX_ERROR_FLAG]  = st.buf_q[g].tx_error_flag;
         txcon_rd[g][`CANTX_BIT_SEND_REQUEST]  = st.buf_q[g].send_request;
         txcon_rd[g][`CANTX_POS_TX_PRIORITY +: 2] = st.buf_q[g].tx_priority;
      end
   end

   // Highest pending event wins the code
   assign pend = st.irq_stat & st.irq_mask;
   always_comb
   begin
      if (pend[6])      interrupt_source_code = 3'h7; // RL8
      else if (pend[5]) interrupt_source_code = 3'h6;
      else if (pend[4]) interrupt_source_code = 3'h5;
      else if (pend[3]) interrupt_source_code = 3'h4;
      else if (pend[2]) interrupt_source_code = 3'h3;
      else if (pend[1]) interrupt_source_code = 3'h2;
      else if (pend[0]) interrupt_source_code = 3'h1;
      else              interrupt_source_code = 3'h0;
   end

   // Arbitration among pending buffers
   always_comb
   begin
      best    = 2'h0;
      any_req = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         if (st.buf_q[i].send_request &&
             (!any_req || st.buf_q[i].tx_priority >= st.buf_q[best].tx_priority))
         begin
            best    = 2'(i); // RL18
            any_req = 1'b1;
         end
      end
   end

   always_comb
   begin
      next_st = st;
      ev      = 7'h00;
      next_st.rsp.ack = rd;
      next_st.rsp.dat = 32'h0000_0000;
      // Four-phase divider: slow base clock is a quarter of the fast one
      next_st.clk_div = st.clk_div + 2'h1;
      if (rd && !wb_we_i)
      begin
         case (wb_adr_i)
            `CANTX_OFS_CTRL:     next_st.rsp.dat = {16'h0000, ctrl_rd};
            `CANTX_OFS_TXCON0:   next_st.rsp.dat = {16'h0000, txcon_rd[0]};
            `CANTX_OFS_TXCON1:   next_st.rsp.dat = {16'h0000, txcon_rd[1]};
            `CANTX_OFS_TXCON2:   next_st.rsp.dat = {16'h0000, txcon_rd[2]};
            `CANTX_OFS_IRQ_STAT: next_st.rsp.dat = {25'h0, st.irq_stat};
            `CANTX_OFS_IRQ_MASK: next_st.rsp.dat = {25'h0, st.irq_mask};
            default:             next_st.rsp.dat = 32'h0000_0000;
         endcase
      end

      // Mode change completes after a settle delay
      if (st.current_mode != st.requested_mode &&
          st.requested_mode != CANTX_RSVD5 && st.requested_mode != CANTX_RSVD6)
      begin
         if (int'(st.mode_cnt) >= MODE_CHG_CYC - 1)
         begin
            next_st.current_mode = st.requested_mode; // RL7
            next_st.mode_cnt     = 3'h0;
         end
         else if (!halt)
            next_st.mode_cnt = st.mode_cnt + 3'h1;
      end
      else
         next_st.mode_cnt = 3'h0;

      // Transmit engine tracking
      case (st.tx_state)
         CANTX_IDLE:
            if (any_req && !halt && st.current_mode != CANTX_CONFIG &&
                st.current_mode != CANTX_DISABLE && !st.abort_all_tx)
            begin
               next_st.tx_state = CANTX_SEND;
               next_st.tx_sel   = best;
            end
         CANTX_SEND:
         begin
            if (tx_done)
            begin
               next_st.buf_q[st.tx_sel].send_request = 1'b0; // RL16
               ev[3 - st.tx_sel] = 1'b1;
               next_st.tx_state = CANTX_IDLE;
            end
            else if (tx_lost_arb || tx_bus_err)
            begin
               // Flags stay set until a new request clears them
               if (tx_lost_arb)
                  next_st.buf_q[st.tx_sel].tx_lost_arbitration_flag = 1'b1; // RL11
               if (tx_bus_err)
               begin
                  next_st.buf_q[st.tx_sel].tx_error_flag = 1'b1; // RL12
                  ev[0] = 1'b1;
               end
               next_st.tx_state = CANTX_IDLE;
            end
            else if (!st.buf_q[st.tx_sel].send_request)
               next_st.tx_state = CANTX_IDLE;
         end
         default: next_st.tx_state = CANTX_IDLE;
      endcase

      // Abort-all cancels every pending request, then clears itself
      if (st.abort_all_tx)
      begin
         for (int i = 0; i < 3; i++)
            if (st.buf_q[i].send_request && !(tx_done && st.tx_sel == 2'(i) &&
                st.tx_state == CANTX_SEND))
            begin
               next_st.buf_q[i].send_request    = 1'b0; // RL3
               next_st.buf_q[i].tx_aborted_flag = 1'b1; // RL10
            end
         next_st.abort_all_tx = 1'b0; // RL4
         next_st.tx_state     = CANTX_IDLE;
      end

      ev[6] = ev_wake;
      ev[5] = ev_rx0;
      ev[4] = ev_rx1;
      if (ev_err)
         ev[0] = 1'b1;

      if (wr && wb_sel_i[1] && wb_sel_i[0])
      begin
         case (wb_adr_i)
            `CANTX_OFS_CTRL:
            begin
               next_st.rx_capture_enable   = wb_dat_i[`CANTX_BIT_CAP]; // RL1
               next_st.stop_in_idle        = wb_dat_i[`CANTX_BIT_SIDL];
               next_st.master_clock_select = wb_dat_i[`CANTX_BIT_CKS];
               next_st.requested_mode =
                  cantx_mode_t'(wb_dat_i[`CANTX_POS_REQUESTED_MODE +: 3]); // RL6
               if (wb_dat_i[`CANTX_BIT_ABORT_ALL_TX])
                  next_st.abort_all_tx = 1'b1; // RL3
            end
            `CANTX_OFS_TXCON0, `CANTX_OFS_TXCON1, `CANTX_OFS_TXCON2:
            begin
               for (int i = 0; i < 3; i++)
                  if (wb_adr_i == 6'(`CANTX_OFS_TXCON0 + 4 * i))
                  begin
                     next_st.buf_q[i].tx_priority = wb_dat_i[`CANTX_POS_TX_PRIORITY +: 2]; // RL17
                     if (wb_dat_i[`CANTX_BIT_SEND_REQUEST])
                     begin
                        next_st.buf_q[i].send_request = 1'b1; // RL14
                        next_st.buf_q[i].tx_aborted_flag = 1'b0; // RL13
                        next_st.buf_q[i].tx_lost_arbitration_flag = 1'b0;
                        next_st.buf_q[i].tx_error_flag = 1'b0;
                     end
                     else if (st.buf_q[i].send_request)
                     begin
                        next_st.buf_q[i].send_request    = 1'b0; // RL15
                        next_st.buf_q[i].tx_aborted_flag = 1'b1; // RL10
                     end
                  end
            end
            `CANTX_OFS_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~wb_dat_i[6:0];
            `CANTX_OFS_IRQ_MASK: next_st.irq_mask = wb_dat_i[6:0];
            default: ;
         endcase
      end
      // Set wins over clear
      next_st.irq_stat = next_st.irq_stat | ev;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '0;
         st.requested_mode <= cantx_mode_t'(`CANTX_RST_MODE); // RL19
         st.current_mode   <= cantx_mode_t'(`CANTX_RST_MODE);
         st.tx_state       <= CANTX_IDLE;
      end
      else
         st <= next_st;
   end

   assign wb_ack_o      = st.rsp.ack;
   assign wb_dat_o      = st.rsp.dat;
   assign tx_start      = st.tx_state == CANTX_SEND && !halt;
   assign tx_buf_sel    = st.tx_sel;
   assign tx_abort      = st.tx_state == CANTX_SEND && !st.buf_q[st.tx_sel].send_request;
   assign can_base_clock_en = (st.master_clock_select ? st.clk_div == 2'h0 : 1'b1) &&
                              !halt; // RL5
   assign rx_capture_on = st.rx_capture_enable;
   assign module_halted = halt;
   assign op_mode       = st.current_mode;
   assign irq           = |pend;

   property p_abort_all_tx_clear;
      @(posedge clk_sys) disable iff (!rst_b)
      st.abort_all_tx |=> !st.abort_all_tx;
   endproperty
   a_abort_all_tx_clear: assert property (p_abort_all_tx_clear) else $error("abort-all stuck"); // RL4

   property p_abort_all_tx_kill;
      @(posedge clk_sys) disable iff (!rst_b)
      st.abort_all_tx && !wr |=> !(|{st.buf_q[0].send_request, st.buf_q[1].send_request,
                                    st.buf_q[2].send_request});
   endproperty
   a_abort_all_tx_kill: assert property (p_abort_all_tx_kill) else $error("abort-all left request"); // RL3

   property p_done_clear;
      @(posedge clk_sys) disable iff (!rst_b)
      st.tx_state == CANTX_SEND && tx_done && !wr |=> !st.buf_q[$past(st.tx_sel)].send_request;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("request not cleared"); // RL16

   property p_req_flags;
      @(posedge clk_sys) disable iff (!rst_b)
      wr && wb_adr_i == `CANTX_OFS_TXCON0 && wb_sel_i[0] && wb_sel_i[1] &&
      wb_dat_i[`CANTX_BIT_SEND_REQUEST] |=> st.buf_q[0].send_request && !st.buf_q[0].tx_aborted_flag;
   endproperty
   a_req_flags: assert property (p_req_flags) else $error("request set failed"); // RL13

   property p_irq;
      @(posedge clk_sys) disable iff (!rst_b)
      irq == (interrupt_source_code != 3'h0);
   endproperty
   a_irq: assert property (p_irq) else $error("code and irq disagree"); // RL8

   property p_rsvd_mode;
      @(posedge clk_sys) disable iff (!rst_b)
      ##1 st.current_mode != CANTX_RSVD5 && st.current_mode != CANTX_RSVD6;
   endproperty
   a_rsvd_mode: assert property (p_rsvd_mode) else $error("reserved mode entered"); // RL6

   property p_halt;
      @(posedge clk_sys) disable iff (!rst_b)
      st.stop_in_idle && cpu_idle |-> !tx_start && !can_base_clock_en;
   endproperty
   a_halt: assert property (p_halt) else $error("ran while idle"); // RL2

   property p_ack;
      @(posedge clk_sys) disable iff (!rst_b)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing"); // Wishbone ack timing, our own choice

   c_send:  cover property (@(posedge clk_sys) disable iff (!rst_b) tx_start ##[1:20] tx_done);
   c_abort_all_tx:  cover property (@(posedge clk_sys) disable iff (!rst_b) st.abort_all_tx);
   c_mode:  cover property (@(posedge clk_sys) disable iff (!rst_b)
                            $changed(st.current_mode));
   c_irq:   cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(irq));
endmodule

// ### testbench/cantx_engine_model.sv
// Behavioural protocol engine facing the transmit-buffer control block.
// Assumes tx_start holds until the block clears or withdraws the request.
`timescale 1ns/1ps
module cantx_engine_model
   import cantx_pkg::*;
#(
   parameter int DLY = 4
)(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Requests from the block, reply choice from the bench
   input  wire logic       tx_start,
   input  wire logic       tx_abort,
   input  wire logic [1:0] reply,
   // Outcome pulses
   output      logic       tx_done,
   output      logic       tx_lost_arb,
   output      logic       tx_bus_err
);
   logic [7:0] cnt;
   // Reply 0 done, 1 lost arbitration, 2 bus error, 3 stall forever
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt         <= 8'h00;
         tx_done     <= 1'b0;
         tx_lost_arb <= 1'b0;
         tx_bus_err  <= 1'b0;
      end
      else
      begin
         tx_done     <= 1'b0;
         tx_lost_arb <= 1'b0;
         tx_bus_err  <= 1'b0;
         if (!tx_start || tx_abort)
            cnt <= 8'h00;
         else if (cnt == DLY[7:0])
         begin
            cnt         <= 8'h00;
            tx_done     <= (reply == 2'h0);
            tx_lost_arb <= (reply == 2'h1);
            tx_bus_err  <= (reply == 2'h2);
         end
         else
            cnt <= cnt + 8'h01;
      end
   end
endmodule

// ### testbench/can_control_and_tx_buffer_ctrl_tb_top.sv
// Self-checking bench for the control and transmit-buffer control block.
// Assumes the behavioural engine model answers transmit requests.
`timescale 1ns/1ps
`include "cantx_regs.svh"
module can_control_and_tx_buffer_ctrl_tb_top
   import cantx_pkg::*;
();
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [5:0]  wb_adr = 6'h00;
   logic [3:0]  wb_sel = 4'hf;
   logic [31:0] wb_dat = 32'h0, wb_dat_o, q;
   logic        wb_ack_o, tx_done, tx_lost_arb, tx_bus_err, tx_start, tx_abort;
   logic        cpu_idle = 1'b0, ev_wake = 1'b0, ev_rx0 = 1'b0, ev_rx1 = 1'b0, ev_err = 1'b0;
   logic        clk_en, cap_on, halted, irq;
   logic [1:0]  tx_buf_sel, reply = 2'h3;
   logic [2:0]  op_mode;
   logic [1:0]  order[$];
   int          err_count = 0, cmp_count = 0;

   always #20 clk_sys = ~clk_sys;

   cantx_ctrl #(.MODE_CHG_CYC(5)) dut_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_idle(cpu_idle), .tx_done(tx_done),
      .tx_lost_arb(tx_lost_arb), .tx_bus_err(tx_bus_err), .ev_wake(ev_wake),
      .ev_rx0(ev_rx0), .ev_rx1(ev_rx1), .ev_err(ev_err), .tx_start(tx_start),
      .tx_buf_sel(tx_buf_sel), .tx_abort(tx_abort), .can_base_clock_en(clk_en),
      .rx_capture_on(cap_on), .module_halted(halted), .op_mode(op_mode), .irq(irq));

   cantx_engine_model #(.DLY(4)) eng_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .tx_start(tx_start), .tx_abort(tx_abort),
      .reply(reply), .tx_done(tx_done), .tx_lost_arb(tx_lost_arb), .tx_bus_err(tx_bus_err));

   always @(posedge clk_sys)
      if (tx_done === 1'b1)
         order.push_back(tx_buf_sel);

   task automatic test_done;
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         err_count++;
      end
   endtask

   task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, a, d};
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 40);
      q = wb_dat_o;
      {wb_cyc, wb_stb} <= 2'b00;
      if (n >= 40)
      begin
         chk(32'h0, 32'h1);
         test_done;
      end
   endtask

   task automatic poll(input logic [5:0] a, input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do
      begin
         wb(1'b0, a, 32'h0);
         n++;
      end
      while ((q & m) !== v && n < 60);
      chk(q & m, v);
      if ((q & m) !== v)
         test_done;
   endtask

   task automatic wait_mode;
      repeat (12) @(posedge clk_sys);
   endtask

   task automatic t_reset;
      wb(1'b0, `CANTX_OFS_CTRL, 32'h0);
      chk(q, 32'h0480);
      wb(1'b0, `CANTX_OFS_TXCON0, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 6'h3c, 32'h0);
      chk(q, 32'h0);
      chk(irq, 32'h0);
   endtask

   task automatic t_ctrl;
      int n;
      cpu_idle <= 1'b1;
      wb(1'b1, `CANTX_OFS_CTRL, 32'hffff_ecff);
      wb(1'b0, `CANTX_OFS_CTRL, 32'h0);
      chk(q, 32'h0000_ac80);
      chk(cap_on, 32'h1);
      chk(halted, 32'h1);
      chk(clk_en, 32'h0);
      cpu_idle <= 1'b0;
      @(posedge clk_sys);
      n = 0;
      repeat (8) @(posedge clk_sys) n += clk_en;
      chk(n, 32'h2);
      wb(1'b1, `CANTX_OFS_CTRL, 32'h0400);
      cpu_idle <= 1'b1;
      n = 0;
      repeat (8) @(posedge clk_sys) n += clk_en;
      chk(n, 32'h8);
      chk(halted, 32'h0);
      chk(cap_on, 32'h0);
      cpu_idle <= 1'b0;
      // Partial byte enables leave the register untouched
      wb_sel <= 4'h1;
      wb(1'b1, `CANTX_OFS_CTRL, 32'h8000);
      wb_sel <= 4'hf;
      chk(cap_on, 32'h0);
   endtask

   task automatic t_modes;
      logic [2:0] req[8] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h4, 3'h0};
      logic [2:0] exp[8] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h7, 3'h4, 3'h0};
      foreach (req[i])
      begin
         wb(1'b1, `CANTX_OFS_CTRL, {21'h0, req[i], 8'h00});
         wait_mode();
         wb(1'b0, `CANTX_OFS_CTRL, 32'h0);
         chk(q[7:5], exp[i]);
         chk(op_mode, exp[i]);
      end
   endtask

   task automatic t_irq;
      int bits[4] = '{6, 5, 4, 0};
      logic [2:0] code[4] = '{3'h7, 3'h6, 3'h5, 3'h1};
      wb(1'b1, `CANTX_OFS_IRQ_STAT, 32'h7f);
      wb(1'b1, `CANTX_OFS_IRQ_MASK, 32'h0);
      {ev_wake, ev_rx0, ev_rx1, ev_err} <= 4'hf;
      @(posedge clk_sys);
      {ev_wake, ev_rx0, ev_rx1, ev_err} <= 4'h0;
      repeat (2) @(posedge clk_sys);
      chk(irq, 32'h0);
      wb(1'b1, `CANTX_OFS_IRQ_MASK, 32'h7f);
      chk(irq, 32'h1);
      foreach (bits[i])
      begin
         wb(1'b0, `CANTX_OFS_CTRL, 32'h0);
         chk(q[3:1], code[i]);
         wb(1'b1, `CANTX_OFS_IRQ_STAT, 32'h1 << bits[i]);
      end
      chk(irq, 32'h0);
   endtask

   task automatic t_send;
      reply <= 2'h0;
      wb(1'b1, `CANTX_OFS_TXCON0, 32'h0b);
      poll(`CANTX_OFS_TXCON0, 32'hff, 32'h03);
      chk(irq, 32'h1);
      wb(1'b0, `CANTX_OFS_CTRL, 32'h0);
      chk(q[3:1], 3'h4);
      wb(1'b1, `CANTX_OFS_IRQ_STAT, 32'h08);
      chk(irq, 32'h0);
   endtask

   task automatic t_prio;
      order.delete();
      wb(1'b1, `CANTX_OFS_CTRL, 32'h0400);
      wait_mode();
      wb(1'b1, `CANTX_OFS_TXCON0, 32'h0a);
      wb(1'b1, `CANTX_OFS_TXCON1, 32'h0b);
      wb(1'b1, `CANTX_OFS_TXCON2, 32'h0b);
      wb(1'b1, `CANTX_OFS_CTRL, 32'h0);
      poll(`CANTX_OFS_TXCON0, 32'h08, 32'h0);
      chk(order.size(), 32'h3);
      chk(order[0], 32'h2);
      chk(order[1], 32'h1);
      chk(order[2], 32'h0);
      wb(1'b1, `CANTX_OFS_IRQ_STAT, 32'h7f);
   endtask

   task automatic t_flags;
      reply <= 2'h1;
      wb(1'b1, `CANTX_OFS_TXCON0, 32'h08);
      poll(`CANTX_OFS_TXCON0, 32'h20, 32'h20);
      reply <= 2'h2;
      poll(`CANTX_OFS_TXCON0, 32'h30, 32'h30);
      reply <= 2'h3;
      wb(1'b1, `CANTX_OFS_TXCON0, 32'h0);
      poll(`CANTX_OFS_TXCON0, 32'h48, 32'h40);
      wb(1'b1, `CANTX_OFS_TXCON0, 32'h08);
      wb(1'b0, `CANTX_OFS_TXCON0, 32'h0);
      chk(q & 32'h78, 32'h08);
      wb(1'b1, `CANTX_OFS_TXCON1, 32'h08);
      wb(1'b1, `CANTX_OFS_TXCON2, 32'h0);
      wb(1'b0, `CANTX_OFS_TXCON2, 32'h0);
      chk(q, 32'h0);
      chk(tx_start, 32'h1);
      chk(tx_buf_sel, 32'h0);
      wb(1'b1, `CANTX_OFS_CTRL, 32'h1000);
      poll(`CANTX_OFS_CTRL, 32'h1000, 32'h0);
      wb(1'b0, `CANTX_OFS_TXCON0, 32'h0);
      chk(q & 32'h48, 32'h40);
      wb(1'b0, `CANTX_OFS_TXCON1, 32'h0);
      chk(q & 32'h48, 32'h40);
   endtask

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_ctrl();
      t_modes();
      t_irq();
      t_send();
      t_prio();
      t_flags();
      test_done();
   end
endmodule
